// ---- design/line_error_counter_access.sv ----
// Overview of operation
// - select codes 1..14 pick channels 0..13
// - one select drives snapshot, clear, readout
// - global clear bit zeroes every counter
// - global snapshot copies all fourteen counters together
// - spare bits writable, zero after reset
// - byte pick chooses low or high byte
// - per-channel snapshot copies only selected counter
// - readout shows chosen byte of selected copy
// - sixteen-bit counters saturate and flag overflow
`timescale 1ns/1ps
`include "lcv_cfg.svh"

module line_error_counter_access #(
  parameter int CHANNELS = `LCV_CHANNELS,
  parameter int COUNT_W = `LCV_COUNT_W,
  parameter int ADDR_W = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [CHANNELS-1:0] violation_event,
  output logic [CHANNELS-1:0] counter_overflow,
  output logic [CHANNELS-1:0] monitor_status
);

  // channel code to one-hot; code 1 is channel 0, so code 0 and the
  // codes above the last channel give all zero and no counter moves
  function automatic logic [CHANNELS-1:0] chan_onehot(
    input logic [3:0] code
  );
    logic [CHANNELS-1:0] hot;
    hot = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (code == 4'(i + 1)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction : chan_onehot

  // register index decode of a byte address; the indices count words,
  // not bytes, so each register sits at four times its index
  // and the two low address bits must be zero for a hit
  function automatic logic idx_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    return (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx)) &&
      (addr[1:0] == 2'b00);
  endfunction : idx_hit

  // the readout port is one byte wide, so a counter is read in two
  // halves picked by the byte pick bit
  localparam int BYTE_W = 8;

  // ---------------------------------------------------------------------
  // bus slave state
  // ---------------------------------------------------------------------
  // wr_pend_q marks the data phase of a write that was taken; the
  // address waits in wr_addr_q until the data arrive
  lcv_pkg::bus_state_t bus_st_q;
  lcv_pkg::bus_state_t bus_st_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [ADDR_W-1:0] wr_addr_d;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [ADDR_W-1:0] rd_addr_d;
  logic [31:0] hrdata_d;
  logic hreadyout_d;
  logic addr_phase;

  // ---------------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------------
  // both software registers keep all eight bits as written
  lcv_pkg::reg_byte_t select_q;
  lcv_pkg::reg_byte_t select_d;
  lcv_pkg::reg_byte_t control_q;
  lcv_pkg::reg_byte_t control_d;
  logic snap_one_prev_q;
  logic snap_all_prev_q;
  logic snap_one_prev_d;
  logic snap_all_prev_d;
  logic select_wr;
  logic control_wr;
  logic [CHANNELS-1:0] overflow_d;
  logic [CHANNELS-1:0] monitor_d;

  // ---------------------------------------------------------------------
  // counter control
  // ---------------------------------------------------------------------
  // per-channel strobes built from the two registers
  logic [3:0] chan_code;
  logic [CHANNELS-1:0] chan_hit;
  logic snap_one_pulse;
  logic snap_all_pulse;
  logic [CHANNELS-1:0] snap_vec;
  logic [CHANNELS-1:0] clr_vec;
  logic [CHANNELS-1:0] sat_vec;
  logic [COUNT_W-1:0] held [CHANNELS];
  logic [7:0] readout_byte_value;

  // address-phase qualifier and the channel picked by the select field
  assign addr_phase = hsel && htrans[1] && hready;
  assign chan_code = select_q[`LCV_SEL_CODE_LSB +: `LCV_SEL_CODE_W];
  assign chan_hit = chan_onehot(chan_code);

  // write strobes of the data phase, decoded once for the register
  // next-state logic
  assign select_wr = wr_pend_q && idx_hit(wr_addr_q, `LCV_IDX_SELECT);
  assign control_wr = wr_pend_q && idx_hit(wr_addr_q, `LCV_IDX_CONTROL);

  // snapshots fire on the rising edge of the stored bit, so one write
  // takes one copy even if software leaves the bit at one; a second
  // copy needs the bit written back to zero first
  always_comb begin
    snap_one_prev_d = control_q[`LCV_CTL_SNAP_ONE_BIT];
    snap_all_prev_d = control_q[`LCV_CTL_SNAP_ALL_BIT];
    snap_one_pulse = control_q[`LCV_CTL_SNAP_ONE_BIT] && !snap_one_prev_q;
    snap_all_pulse = control_q[`LCV_CTL_SNAP_ALL_BIT] && !snap_all_prev_q;
    snap_vec = {CHANNELS{snap_all_pulse}};
    if (snap_one_pulse) begin
      snap_vec = snap_vec | chan_hit;
    end
  end

  // clears are levels: counters stay at zero while the bit is held,
  // which is why the host must keep it high long enough; the channel
  // clear follows the select field, so moving the select while the bit
  // is high moves the clear to the new channel
  always_comb begin
    clr_vec = {CHANNELS{control_q[`LCV_CTL_CLR_ALL_BIT]}};
    if (control_q[`LCV_CTL_CLR_ONE_BIT]) begin
      clr_vec = clr_vec | chan_hit;
    end
  end

  // one counter and holding copy per channel; a global snapshot hits
  // every copy on the same edge, so the fourteen values are coherent,
  // and counting goes on while the copy is taken
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      lcv_counter #(
        .WIDTH(COUNT_W)
      ) u_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .violation(violation_event[g]),
        .clear(clr_vec[g]),
        .snapshot(snap_vec[g]),
        .held_q(held[g]),
        .saturated_q(sat_vec[g])
      );
    end
  endgenerate

  // readout mux; no channel selected reads as zero. only the holding
  // copies are read, so a count moving during the bus read cannot tear
  // the two bytes apart
  always_comb begin
    readout_byte_value = 8'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      if (chan_hit[i]) begin
        if (control_q[`LCV_CTL_BYTE_PICK_BIT]) begin
          readout_byte_value = held[i][COUNT_W-1 -: BYTE_W];
        end else begin
          readout_byte_value = held[i][BYTE_W-1:0];
        end
      end
    end
  end

  // overflow flags and the monitor pin, which shows either the raw
  // violation activity or the saturation state per channel; both are
  // registered, so a select write never glitches the pins, at the cost
  // of one cycle of delay
  always_comb begin
    overflow_d = sat_vec;
    if (select_q[`LCV_SEL_MONITOR_BIT]) begin
      monitor_d = sat_vec;
    end else begin
      monitor_d = violation_event;
    end
  end

  // ---------------------------------------------------------------------
  // AHB-Lite slave: writes take no wait state, reads take one so the
  // read data come from a flop and always see the previous write
  // write: taken at edge 1, register updated at edge 2
  // read: ready low after edge 1, data and ready high after edge 2
  // hsize is not decoded: each register is one byte inside a word and
  // only whole-word transfers are expected
  // ---------------------------------------------------------------------
  always_comb begin
    bus_st_d = bus_st_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    rd_addr_d = rd_addr_q;
    hrdata_d = hrdata;
    hreadyout_d = 1'b1;
    case (bus_st_q)
      lcv_pkg::BUS_IDLE: begin
        if (addr_phase) begin
          if (hwrite) begin
            // only the address is kept; the data follow a cycle later
            wr_pend_d = 1'b1;
            wr_addr_d = haddr;
          end else begin
            // one stall cycle while the read word is built
            rd_addr_d = haddr;
            hreadyout_d = 1'b0;
            bus_st_d = lcv_pkg::BUS_RD_WAIT;
          end
        end
      end
      lcv_pkg::BUS_RD_WAIT: begin
        // unmapped reads return zero with an OKAY response
        // the word sees any write that landed in the cycle before
        hrdata_d = 32'h0000_0000;
        if (idx_hit(rd_addr_q, `LCV_IDX_SELECT)) begin
          hrdata_d = {24'h00_0000, select_q};
        end else if (idx_hit(rd_addr_q, `LCV_IDX_CONTROL)) begin
          hrdata_d = {24'h00_0000, control_q};
        end else if (idx_hit(rd_addr_q, `LCV_IDX_READOUT)) begin
          hrdata_d = {24'h00_0000, readout_byte_value};
        end
        hreadyout_d = 1'b1;
        bus_st_d = lcv_pkg::BUS_IDLE;
      end
      default: begin
        // an illegal state code returns to idle and drops the read
        bus_st_d = lcv_pkg::BUS_IDLE;
      end
    endcase
  end

  // register writes land in the data phase; spare bits are kept as
  // written, the readout register ignores writes
  always_comb begin
    select_d = select_q;
    control_d = control_q;
    if (select_wr) begin
      select_d = hwdata[7:0];
    end
    if (control_wr) begin
      control_d = hwdata[7:0];
    end
  end

  // bus flops; the response is registered too, so every bus output
  // leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_q <= lcv_pkg::BUS_IDLE;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rd_addr_q <= '0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      bus_st_q <= bus_st_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rd_addr_q <= rd_addr_d;
      hrdata <= hrdata_d;
      hreadyout <= hreadyout_d;
      hresp <= 1'b0; // always OKAY
    end
  end

  // register and status flops; the edge detectors reset to the same
  // zero as the control bits, so no false snapshot follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      select_q <= `LCV_SELECT_RST;
      control_q <= `LCV_CONTROL_RST;
      snap_one_prev_q <= 1'b0;
      snap_all_prev_q <= 1'b0;
      counter_overflow <= '0;
      monitor_status <= '0;
    end else begin
      select_q <= select_d;
      control_q <= control_d;
      snap_one_prev_q <= snap_one_prev_d;
      snap_all_prev_q <= snap_all_prev_d;
      counter_overflow <= overflow_d;
      monitor_status <= monitor_d;
    end
  end

endmodule : line_error_counter_access

// ---- design/lcv_cfg.svh ----
`ifndef LCV_CFG_SVH
`define LCV_CFG_SVH

// register indices; byte address is four times the index
`define LCV_IDX_SELECT 8'he5
`define LCV_IDX_CONTROL 8'he6
`define LCV_IDX_READOUT 8'he8

// reset values
`define LCV_SELECT_RST 8'h00
`define LCV_CONTROL_RST 8'h00

// select register fields
`define LCV_SEL_CODE_LSB 0
`define LCV_SEL_CODE_W 4
`define LCV_SEL_MONITOR_BIT 7

// control register fields
`define LCV_CTL_CLR_ONE_BIT 0
`define LCV_CTL_SNAP_ONE_BIT 1
`define LCV_CTL_BYTE_PICK_BIT 2
`define LCV_CTL_SNAP_ALL_BIT 3
`define LCV_CTL_CLR_ALL_BIT 4

// channel codes: first code maps to channel 0
`define LCV_CODE_FIRST 4'h1
`define LCV_CODE_LAST 4'he

// host hold of a clear bit: one microsecond of the 5 ns clock
`define LCV_CLEAR_HOLD_CYCLES 200

// counter geometry
`define LCV_CHANNELS 14
`define LCV_COUNT_W 16

`endif

// ---- design/lcv_pkg.sv ----
package lcv_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RD_WAIT = 2'b10
  } bus_state_t;

  typedef logic [7:0] reg_byte_t;

endpackage : lcv_pkg

// ---- design/lcv_counter.sv ----
`timescale 1ns/1ps
`include "lcv_cfg.svh"

module lcv_counter #(
  parameter int WIDTH = `LCV_COUNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic violation,
  input wire logic clear,
  input wire logic snapshot,
  output logic [WIDTH-1:0] held_q,
  output logic saturated_q
);

  localparam logic [WIDTH-1:0] MAX_COUNT = {WIDTH{1'b1}};

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic [WIDTH-1:0] held_d;
  logic saturated_d;

  // counting never pauses for a snapshot; clear beats an arriving violation
  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = '0;
    end else if (violation && count_q != MAX_COUNT) begin
      count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
    held_d = snapshot ? count_q : held_q;
    saturated_d = (count_d == MAX_COUNT);
  end

  // holding copy is separate so software reads a stable value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= '0;
      held_q <= '0;
      saturated_q <= 1'b0;
    end else begin
      count_q <= count_d;
      held_q <= held_d;
      saturated_q <= saturated_d;
    end
  end

endmodule : lcv_counter

// ---- dv/lcv_access_properties.sv ----
`timescale 1ns/1ps
module lcv_access_properties #(
  parameter int CHANNELS = 14
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [CHANNELS-1:0] violation_event,
  input wire logic [CHANNELS-1:0] counter_overflow
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a transfer is taken with select, a NONSEQ or SEQ type and ready
  wire take = hsel && htrans[1] && hready;
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  write_fast_a: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take && !hwrite))
    else $error("stall without read");
  short_wait_a: assert property (!hreadyout |=> hreadyout)
    else $error("stall too long");
  byte_wide_a: assert property (hrdata[31:8] == 24'h0)
    else $error("readout wider than a byte");
  rdata_hold_a: assert property ($changed(hrdata) |-> $past(!hreadyout))
    else $error("read data moved");
  sat_cause_a: assert property ($rose(counter_overflow[0]) |->
    $past(violation_event[0]) || $past(violation_event[0], 2))
    else $error("overflow without violation");
endmodule : lcv_access_properties

bind line_error_counter_access lcv_access_properties #(
  .CHANNELS(CHANNELS)
) lcv_access_properties_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .violation_event(violation_event), .counter_overflow(counter_overflow)
);

// ---- dv/lcv_host_model.sv ----
`timescale 1ns/1ps
`include "lcv_cfg.svh"
module lcv_host_model (
  input wire logic hclk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [9:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hang
);
  // idle bus at time zero; only word transfers are made
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, hang} = '0;
    hsize = 3'h2;
  end
  // single transfer; a stuck ready raises hang instead of waiting forever
  task automatic xfer(input logic [9:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do begin
      @(posedge hclk);
      n++;
    end while (!hreadyout && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do begin
      @(posedge hclk);
      n++;
    end while (!hreadyout && n < 64);
    q = hrdata;
    hwdata <= ~d; // released data never shows the last value
    hang <= (n >= 64);
  endtask : xfer
  // clear bits act as a level, so keep them up a full microsecond
  task automatic hold_clear(input logic [9:0] a, input logic [7:0] b);
    logic [31:0] q;
    xfer(a, 1'b1, {24'h0, b}, q);
    repeat (`LCV_CLEAR_HOLD_CYCLES) @(posedge hclk);
    xfer(a, 1'b1, 32'h0, q);
  endtask : hold_clear
endmodule : lcv_host_model

// ---- dv/tb_line_error_counter_access.sv ----
`timescale 1ns/1ps
`include "lcv_cfg.svh"
module tb_line_error_counter_access;
  localparam logic [9:0] sel_a = {`LCV_IDX_SELECT, 2'b00};
  localparam logic [9:0] ctl_a = {`LCV_IDX_CONTROL, 2'b00};
  localparam logic [9:0] out_a = {`LCV_IDX_READOUT, 2'b00};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, hang;
  logic [9:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [13:0] ev, ovf, mon;
  int error_cnt, n_checks;
  line_error_counter_access line_error_counter_access_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .violation_event(ev), .counter_overflow(ovf),
    .monitor_status(mon)
  );
  lcv_host_model lcv_host_model_inst (
    .hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hang(hang)
  );
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    lcv_host_model_inst.xfer(a, 1'b1, {24'h0, d}, q);
  endtask : wr
  task automatic rd(input string nm, input logic [9:0] a, logic [7:0] e);
    lcv_host_model_inst.xfer(a, 1'b0, 32'h0, q);
    chk(nm, q, {24'h0, e});
  endtask : rd
  task automatic rd_ch(input int c, input logic [7:0] e);
    wr(sel_a, 8'(c + 1));
    rd("readout", out_a, e);
  endtask : rd_ch
  // violations arrive one per cycle while the mask is up
  task automatic burst(input int n, input logic [13:0] m);
    repeat (n) begin
      ev <= m;
      @(posedge hclk);
    end
    ev <= 14'h0;
    @(posedge hclk); // a quiet cycle keeps back-to-back bursts apart
  endtask : burst
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // a stuck bus counts as a failure and ends the run
  always @(posedge hang) begin
    error_cnt++;
    final_report();
  end
  initial begin
    {hresetn, ev, error_cnt, n_checks} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("select", sel_a, 8'h00);
    rd("control", ctl_a, 8'h00);
    wr(ctl_a, 8'he0);
    rd("control spare", ctl_a, 8'he0);
    wr(sel_a, 8'h10);
    rd("select spare", sel_a, 8'h10);
    wr(10'h39c, 8'hff);
    rd("unmapped", 10'h39c, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 14; i++) burst(i + 3, 14'h1 << i);
    burst(297, 14'h1);
    wr(ctl_a, 8'h00);
    wr(ctl_a, 8'h08);
    for (int i = 0; i < 14; i++) rd_ch(i, i ? 8'(i + 3) : 8'h2c);
    wr(sel_a, 8'h0f);
    rd("no channel", out_a, 8'h00);
    wr(sel_a, 8'h01);
    wr(ctl_a, 8'h0c);
    rd("high byte", out_a, 8'h01);
    $display("test snapshot all done");
    burst(5, 14'h3fff);
    wr(ctl_a, 8'h00);
    wr(sel_a, 8'h03);
    wr(ctl_a, 8'h02);
    rd("one copy", out_a, 8'd10);
    wr(sel_a, 8'h04);
    rd("other copy", out_a, 8'd6);
    wr(sel_a, 8'h03);
    wr(ctl_a, 8'h00);
    lcv_host_model_inst.hold_clear(ctl_a, 8'h01);
    wr(ctl_a, 8'h08);
    rd_ch(2, 8'h00);
    rd_ch(3, 8'd11);
    $display("test one channel done");
    burst(65540, 14'h1);
    wr(ctl_a, 8'h00);
    chk("overflow", 32'(ovf), 32'h1);
    wr(ctl_a, 8'h08);
    rd_ch(0, 8'hff);
    wr(ctl_a, 8'h0c);
    rd("sat high", out_a, 8'hff);
    // monitor pin: saturation view, then the raw violation view
    wr(sel_a, 8'h81);
    repeat (2) @(posedge hclk);
    chk("monitor ovf", 32'(mon), 32'h1);
    wr(sel_a, 8'h01);
    ev <= 14'h2aaa;
    repeat (2) @(posedge hclk);
    chk("monitor raw", 32'(mon), 32'h2aaa);
    ev <= 14'h0;
    $display("test saturation done");
    lcv_host_model_inst.hold_clear(ctl_a, 8'h10);
    wr(ctl_a, 8'h08);
    chk("overflow clear", 32'(ovf), 32'h0);
    rd_ch(0, 8'h00);
    rd_ch(13, 8'h00);
    $display("test clear all done");
    final_report();
  end
endmodule : tb_line_error_counter_access
